/* core/ecw_cyclic_io.sv */
`timescale 1ns/10ps
module ecw_cyclic_io
	import ecw_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic cycle_strobe,
	input wire logic [WORD_W-1:0] controller_control_word,
	input wire logic [WORD_W-1:0] sensor_control_word,
	input wire logic [ST_BITS-1:0] singleturn_count,
	input wire logic [MT_BITS-1:0] multiturn_count,
	input wire logic compat_mode,
	input wire logic class4_enable,
	input wire logic local_control_only,
	input wire logic error_active,
	input wire logic [POS_W-1:0] error_code,
	input wire logic preset_param_wr,
	input wire logic [POS_W-1:0] preset_param_data,
	input wire logic [WIDE_W-1:0] stored_offset,
	input wire logic restore_offset,
	output logic [POS_W-1:0] primary_position_word,
	output logic [POS_W-1:0] secondary_position_word,
	output logic [WIDE_W-1:0] wide_position_word,
	output logic [WORD_W-1:0] encoder_status_word,
	output logic [WORD_W-1:0] sensor_status_word,
	output logic [WIDE_W-1:0] offset_value,
	output logic comm_lost
);
	ecw_offset_if ofs_bus();
	ecw_preset_state_type pr_state_reg;
	ecw_preset_state_type pr_state_next;
	logic [POS_W-1:0] preset_reg;
	logic [3:0] dev_hb_reg;
	logic [3:0] last_hb_reg;
	logic [2:0] stall_cnt_reg;
	logic ack_seen_reg;
	logic [WIDE_W-1:0] raw_pos;
	logic [WIDE_W-1:0] adj_pos;
	logic [WIDE_W-1:0] ofs;
	logic ctrl_valid;
	logic preset_req;
	logic relative_mode;
	logic cyclic_req;
	logic park_req;
	logic ack_req;
	logic err_shown;
	logic [WIDE_W-1:0] abs_offset;
	logic [WIDE_W-1:0] rel_offset;
	logic [3:0] ctrl_hb;

	ecw_offset_store u_store (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.restore_value(stored_offset),
		.restore_en(restore_offset),
		.port(ofs_bus.store)
	);

	assign raw_pos = {{(WIDE_W-ST_BITS-MT_BITS){1'b0}}, multiturn_count, singleturn_count};
	assign ofs = ofs_bus.rd_data;
	assign adj_pos = raw_pos + ofs;

	assign ctrl_valid = compat_mode | controller_control_word[CCW_PLC_BIT];
	assign preset_req = ctrl_valid & sensor_control_word[SCW_PRESET_BIT];
	assign relative_mode = sensor_control_word[SCW_HOME_MODE_BIT];
	assign cyclic_req = ctrl_valid & sensor_control_word[SCW_CYCLIC_BIT];
	assign park_req = ctrl_valid & sensor_control_word[SCW_PARK_BIT];
	assign ack_req = ctrl_valid & sensor_control_word[SCW_ACK_BIT];
	assign err_shown = error_active & ~park_req;
	assign abs_offset = {{(WIDE_W-POS_W){1'b0}}, preset_reg} - raw_pos;
	assign rel_offset = ofs + {{(WIDE_W-POS_W){1'b0}}, preset_reg};
	assign ctrl_hb = controller_control_word[HB_MSB:HB_LSB];

	assign ofs_bus.wr_en = (pr_state_reg == ECW_PR_APPLY);
	assign ofs_bus.wr_data = relative_mode ? rel_offset : abs_offset;

	always_comb begin
		pr_state_next = pr_state_reg;
		case (pr_state_reg)
			ECW_PR_IDLE: begin
				if (cycle_strobe && preset_req) begin
					pr_state_next = ECW_PR_APPLY;
				end
			end
			ECW_PR_APPLY: begin
				pr_state_next = ECW_PR_DONE;
			end
			ECW_PR_DONE: begin
				// Request bit counts as clear while control is not valid
				if (cycle_strobe && !preset_req) begin
					pr_state_next = ECW_PR_IDLE;
				end
			end
			default: begin
				pr_state_next = ECW_PR_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pr_state_reg <= ECW_PR_IDLE;
		end else begin
			pr_state_reg <= pr_state_next;
		end
	end

	// preset defaults to zero, parameter write only
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			preset_reg <= PRESET_RST;
		end else if (preset_param_wr) begin
			preset_reg <= preset_param_data;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			dev_hb_reg <= HB_RST;
			last_hb_reg <= HB_RST;
			stall_cnt_reg <= 3'h0;
			comm_lost <= 1'b0;
		end else if (cycle_strobe) begin
			dev_hb_reg <= dev_hb_reg + 4'h1;
			last_hb_reg <= ctrl_hb;
			if (ctrl_hb == last_hb_reg) begin
				if (stall_cnt_reg != HB_LOSS_LIMIT) begin
					stall_cnt_reg <= stall_cnt_reg + 3'h1;
				end
				comm_lost <= (stall_cnt_reg + 3'h1 >= HB_LOSS_LIMIT);
			end else begin
				stall_cnt_reg <= 3'h0;
				comm_lost <= 1'b0;
			end
		end
	end

	// Error acknowledge seen, held until request drops
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_seen_reg <= 1'b0;
		end else if (cycle_strobe) begin
			ack_seen_reg <= ack_req;
		end
	end

	// Outputs refreshed once per network cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			primary_position_word <= '0;
			secondary_position_word <= '0;
			wide_position_word <= '0;
			encoder_status_word <= WORD_RST;
			sensor_status_word <= WORD_RST;
			offset_value <= OFFSET_RST;
		end else if (cycle_strobe) begin
			primary_position_word <= adj_pos[POS_W-1:0];
			if (err_shown) begin
				secondary_position_word <= error_code;
			end else if (cyclic_req) begin
				secondary_position_word <= adj_pos[POS_W-1:0];
			end else begin
				secondary_position_word <= '0;
			end
			wide_position_word <= class4_enable ? adj_pos : raw_pos;
			encoder_status_word <= {dev_hb_reg, 2'b00, ~local_control_only, 9'h000};
			sensor_status_word <= {err_shown, park_req, cyclic_req & ~err_shown,
				pr_state_reg == ECW_PR_DONE, ack_seen_reg, 11'h000};
			offset_value <= ofs;
		end
	end
endmodule

/* core/ecw_pkg.sv */
package ecw_pkg;
	localparam int POS_W = 32;
	localparam int WIDE_W = 64;
	localparam int WORD_W = 16;
	localparam int ST_BITS = 13;
	localparam int MT_BITS = 12;
	// Controller control word fields
	localparam int CCW_PLC_BIT = 10;
	localparam int HB_LSB = 12;
	localparam int HB_MSB = 15;
	// Encoder status word fields
	localparam int ESW_CTRL_REQ_BIT = 9;
	// Sensor control word fields
	localparam int SCW_HOME_MODE_BIT = 11;
	localparam int SCW_PRESET_BIT = 12;
	localparam int SCW_CYCLIC_BIT = 13;
	localparam int SCW_PARK_BIT = 14;
	localparam int SCW_ACK_BIT = 15;
	// Sensor status word fields
	localparam int SSW_ACK_SEEN_BIT = 11;
	localparam int SSW_PRESET_DONE_BIT = 12;
	localparam int SSW_CYCLIC_BIT = 13;
	localparam int SSW_PARK_BIT = 14;
	localparam int SSW_ERR_BIT = 15;
	// Reset values and heartbeat loss limit
	localparam logic [POS_W-1:0] PRESET_RST = 32'h0000_0000;
	localparam logic [WIDE_W-1:0] OFFSET_RST = 64'h0000_0000_0000_0000;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	localparam logic [3:0] HB_RST = 4'h0;
	localparam logic [2:0] HB_LOSS_LIMIT = 3'h3;
	typedef enum logic [2:0] {
		ECW_PR_IDLE = 3'b001,
		ECW_PR_APPLY = 3'b010,
		ECW_PR_DONE = 3'b100
	} ecw_preset_state_type;
endpackage

/* core/ecw_offset_if.sv */
`timescale 1ns/10ps
interface ecw_offset_if;
	logic wr_en;
	logic [63:0] wr_data;
	logic [63:0] rd_data;
	modport ctrl(output wr_en, output wr_data, input rd_data);
	modport store(input wr_en, input wr_data, output rd_data);
endinterface

/* core/ecw_offset_store.sv */
`timescale 1ns/10ps
// Holds the preset offset; stands in for the retained store.
module ecw_offset_store
	import ecw_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [WIDE_W-1:0] restore_value,
	input wire logic restore_en,
	ecw_offset_if.store port
);
	logic [WIDE_W-1:0] mem_reg;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_reg <= OFFSET_RST;
		end else if (port.wr_en) begin
			mem_reg <= port.wr_data;
		end else if (restore_en) begin
			mem_reg <= restore_value;
		end
	end
	assign port.rd_data = mem_reg;
endmodule

/* dv/ecw_plc_model.sv */
`timescale 1ns/10ps
module ecw_plc_model
	import ecw_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic cycle_strobe,
	input wire logic plc_flag,
	input wire logic hb_run,
	output logic [WORD_W-1:0] controller_control_word
);
	logic [3:0] hb_reg;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hb_reg <= HB_RST;
		end else if (cycle_strobe && hb_run) begin
			hb_reg <= hb_reg + 4'h1;
		end
	end
	assign controller_control_word = {hb_reg, 1'h0, plc_flag, 10'h000};
endmodule

/* dv/ecw_cyclic_io_sva.sv */
`timescale 1ns/10ps
module ecw_cyclic_io_sva
	import ecw_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic cycle_strobe,
	input wire logic [WORD_W-1:0] controller_control_word,
	input wire logic [WORD_W-1:0] sensor_control_word,
	input wire logic [ST_BITS-1:0] singleturn_count,
	input wire logic [MT_BITS-1:0] multiturn_count,
	input wire logic compat_mode,
	input wire logic error_active,
	input wire logic [POS_W-1:0] error_code,
	input wire logic [POS_W-1:0] primary_position_word,
	input wire logic [POS_W-1:0] secondary_position_word,
	input wire logic [WORD_W-1:0] encoder_status_word,
	input wire logic [WORD_W-1:0] sensor_status_word,
	input wire logic [WIDE_W-1:0] offset_value
);
	wire en = compat_mode || controller_control_word[CCW_PLC_BIT];
	wire [31:0] pos = {7'h00, multiturn_count, singleturn_count};
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_req;
		cycle_strobe && en && sensor_control_word[SCW_PRESET_BIT] && !sensor_status_word[SSW_PRESET_DONE_BIT];
	endsequence
	property p_prim; cycle_strobe |=> primary_position_word == $past(pos) + offset_value[31:0]; endproperty
	a_prim: assert property (p_prim) else $error("primary wrong");
	property p_zero; cycle_strobe && !error_active && !(en && sensor_control_word[13]) |=> secondary_position_word == 0; endproperty
	a_zero: assert property (p_zero) else $error("secondary not zero");
	property p_err; cycle_strobe && error_active && !(en && sensor_control_word[14]) |=> secondary_position_word == $past(error_code); endproperty
	a_err: assert property (p_err) else $error("error code missing");
	property p_hold; !cycle_strobe |=> $stable(primary_position_word) && $stable(encoder_status_word); endproperty
	a_hold: assert property (p_hold) else $error("output moved");
	property p_hb; cycle_strobe && encoder_status_word[15:12] != 0 |=> encoder_status_word[15:12] == $past(encoder_status_word[15:12]) + 4'h1; endproperty
	a_hb: assert property (p_hb) else $error("heartbeat stuck");
	property p_park; cycle_strobe && en && sensor_control_word[14] |=> sensor_status_word[15:14] == 2'h1; endproperty
	a_park: assert property (p_park) else $error("park status wrong");
	property p_done; s_req |-> ##[1:16] sensor_status_word[SSW_PRESET_DONE_BIT]; endproperty
	a_done: assert property (p_done) else $error("preset not done");
	property p_clr; cycle_strobe && sensor_status_word[12] && !(en && sensor_control_word[12]) |-> ##[1:12] !sensor_status_word[12]; endproperty
	a_clr: assert property (p_clr) else $error("done not cleared");
endmodule
bind ecw_cyclic_io ecw_cyclic_io_sva u_ecw_cyclic_io_sva (.core_clk, .arst_n, .cycle_strobe, .controller_control_word,
	.sensor_control_word, .singleturn_count, .multiturn_count, .compat_mode, .error_active, .error_code,
	.primary_position_word, .secondary_position_word, .encoder_status_word, .sensor_status_word, .offset_value);

/* dv/testbench.sv */
`timescale 1ns/10ps
module testbench
	import ecw_pkg::*;
;
	logic core_clk = 1'h0, arst_n = 1'h0, cycle_strobe = 1'h0, plc_flag = 1'h1, hb_run = 1'h1, compat_mode = 1'h0;
	logic class4_enable = 1'h0, local_control_only = 1'h0, error_active = 1'h0, preset_param_wr = 1'h0, comm_lost;
	logic [15:0] sensor_control_word = 16'h0000, controller_control_word, encoder_status_word, sensor_status_word;
	logic [12:0] singleturn_count = 13'h1abc;
	logic [11:0] multiturn_count = 12'h5a5;
	logic [31:0] error_code = 32'h0000_0003, preset_param_data = 32'h0000_1000;
	logic [31:0] primary_position_word, secondary_position_word;
	logic [63:0] wide_position_word, offset_value;
	wire [63:0] pos = {39'h0, multiturn_count, singleturn_count};
	logic [1:0] phase_reg = 2'h0;
	int err_total = 0, total_checks = 0, cycles = 0;
	ecw_plc_model u_ecw_plc_model (.core_clk, .arst_n, .cycle_strobe, .plc_flag, .hb_run, .controller_control_word);
	ecw_cyclic_io u_ecw_cyclic_io (.core_clk, .arst_n, .cycle_strobe, .controller_control_word, .sensor_control_word,
		.singleturn_count, .multiturn_count, .compat_mode, .class4_enable, .local_control_only, .error_active,
		.error_code, .preset_param_wr, .preset_param_data, .stored_offset(64'h0), .restore_offset(1'h0),
		.primary_position_word, .secondary_position_word, .wide_position_word, .encoder_status_word,
		.sensor_status_word, .offset_value, .comm_lost);
	always #25 core_clk = ~core_clk;
	// One network cycle every four clocks
	always @(posedge core_clk) begin
		phase_reg <= phase_reg + 2'h1;
		cycle_strobe <= (phase_reg == 2'h3);
		cycles++;
		if (cycles > 3000) begin
			err_total++;
			wrap_up();
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	// Settle past four strobes, which covers the preset steps
	task automatic scw(input logic [15:0] v);
		@(posedge core_clk) sensor_control_word <= v;
		repeat (16) @(posedge core_clk);
		#1;
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		arst_n <= 1'h1;
		scw(16'h0000);
		chk(primary_position_word, pos);
		chk(wide_position_word, pos);
		chk(secondary_position_word, 64'h0);
		chk(encoder_status_word[9], 1'h1);
		scw(16'h2000);
		chk(secondary_position_word, pos);
		@(posedge core_clk) plc_flag <= 1'h0;
		scw(16'h2000);
		chk(secondary_position_word, 64'h0);
		@(posedge core_clk) compat_mode <= 1'h1;
		scw(16'h2000);
		chk(secondary_position_word, pos);
		@(posedge core_clk) error_active <= 1'h1;
		scw(16'h2000);
		chk(secondary_position_word, error_code);
		scw(16'h4000);
		chk(sensor_status_word[15:14], 2'h1);
		@(posedge core_clk) error_active <= 1'h0;
		scw(16'h8000);
		chk(sensor_status_word[11], 1'h1);
		scw(16'h1000);
		chk(sensor_status_word[12], 1'h1);
		chk(primary_position_word, 64'h0);
		scw(16'h0800);
		chk(sensor_status_word[12], 1'h0);
		@(posedge core_clk) preset_param_wr <= 1'h1;
		@(posedge core_clk) preset_param_wr <= 1'h0;
		scw(16'h1800);
		chk(primary_position_word, 64'h1000);
		@(posedge core_clk) class4_enable <= 1'h1;
		scw(16'h0000);
		chk(wide_position_word, 64'h1000);
		@(posedge core_clk) hb_run <= 1'h0;
		@(posedge core_clk) local_control_only <= 1'h1;
		scw(16'h0000);
		chk(comm_lost, 1'h1);
		chk(encoder_status_word[9], 1'h0);
		wrap_up();
	end
endmodule
